// ===== hdl/line_state_map.svh
// Purpose: Register offsets, field positions, reset values, frame counts.
// Assumes: Included by bare name in the top module.
// Notes: Definitions only.
`ifndef LINE_STATE_MAP_SVH
`define LINE_STATE_MAP_SVH
`define ADDR_W 8
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_EVENT 8'h08
`define OFS_MASK 8'h0c
`define CTL_W 5
`define CTL_RST 5'h01
`define CH2_LSB 8
`define FLD_LOOP_LSB 0
`define FLD_TRIP_LSB 2
`define FLD_THERM_BIT 4
`define FRAME_BITS 4'ha
`define EV_THERM_LSB 0
`define EV_LOOP_LSB 2
`define EV_FRAME_OK 4
`define EV_FRAME_ERR 5
`define EV_W 6
`define MASK_RST 6'h00
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3
`endif

// ===== hdl/line_state_pkg.sv
// Purpose: Shared types of the line state controller.
// Assumes: Numbers live in line_state_map.svh.
// Notes: Control word bit 4 test load, bit 3 high limit, bits 2..0 state.
package line_state_pkg;
    typedef enum logic [2:0] {
        ST_SCAN = 3'h0, ST_FWD = 3'h1, ST_FWD_RCM = 3'h2, ST_REV = 3'h3,
        ST_TIP_OPEN = 3'h4, ST_WINK = 3'h5, ST_RINGING = 3'h6,
        ST_DISC = 3'h7
    } line_state_e;
    typedef struct packed {
        logic test_load;
        logic high_limit;
        line_state_e state;
    } chan_ctrl_s;
    typedef enum logic [1:0] {
        LK_IDLE = 2'h0, LK_SHIFT = 2'h1, LK_CHECK = 2'h3
    } link_e;
    typedef enum logic [2:0] {
        SEL_CTRL = 3'h0, SEL_STATUS = 3'h1, SEL_EVENT = 3'h2,
        SEL_MASK = 3'h3, SEL_NONE = 3'h4
    } sel_e;
    typedef struct packed {
        logic all_off;
        logic tip_hiz;
        logic ring_hiz;
        logic reverse;
        logic raised_common_mode;
        logic wink_ground;
        logic ring_amp_en;
        logic ac_path_en;
        logic onhook_tx_en;
        logic loop_det_en;
        logic fixed_limit;
        logic low_current_limit;
        logic high_current_limit;
        logic test_load_pin;
    } drive_s;
endpackage

// ===== hdl/link_if.sv
// Purpose: Sampled serial link events between sampler and core.
// Assumes: All signals on aclk.
// Notes: Edge flags are one-cycle pulses.
`timescale 1ns/100ps
interface link_if;
    logic en;
    logic en_rise;
    logic en_fall;
    logic clk_rise;
    logic clk_fall;
    logic din;
    modport sampler(output en, en_rise, en_fall, clk_rise, clk_fall, din);
    modport core(input en, en_rise, en_fall, clk_rise, clk_fall, din);
endinterface

// ===== hdl/link_sampler.sv
// Purpose: Synchronise the serial pins and find link clock edges.
// Assumes: Link clock half period spans at least three aclk cycles.
// Notes: Edges are seen two to three cycles after the pin moves.
`timescale 1ns/100ps

module link_sampler
    import line_state_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Serial pins
    input wire logic ser_en,
    input wire logic ser_clk,
    input wire logic ser_din,
    // Sampled link toward the core
    link_if.sampler lk
);
    typedef struct packed {
        logic [2:0] s1;
        logic [2:0] s2;
        logic [1:0] old;
    } smp_s;
    smp_s st_r;
    smp_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = {ser_en, ser_clk, ser_din};
        st_nxt.s2 = st_r.s1;
        st_nxt.old = st_r.s2[2:1];
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign lk.en = st_r.s2[2];
    assign lk.en_rise = st_r.s2[2] & ~st_r.old[1];
    assign lk.en_fall = ~st_r.s2[2] & st_r.old[1];
    assign lk.clk_rise = st_r.s2[1] & ~st_r.old[0];
    assign lk.clk_fall = ~st_r.s2[1] & st_r.old[0];
    assign lk.din = st_r.s2[0];
endmodule

// ===== hdl/line_channel.sv
// Purpose: One line channel: thermal hysteresis and state decode.
// Assumes: Thermal comparator flags are already synchronised.
// Notes: Drive outputs are registered, one cycle behind control.
`timescale 1ns/100ps

module line_channel
    import line_state_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Programmed control and thermal comparators
    input wire chan_ctrl_s ctrl,
    input wire logic therm_over,
    input wire logic therm_cool,
    // Line drive and shutdown flag
    output drive_s drive,
    output logic hot
);
    typedef struct packed {
        logic hot;
        drive_s drv;
    } chn_s;
    localparam drive_s DRV_FWD = '{loop_det_en: 1'b1, ac_path_en: 1'b1,
        onhook_tx_en: 1'b1, low_current_limit: 1'b1, default: 1'b0};
    chn_s st_r;
    chn_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        // Two trip points give hysteresis; the hot trip wins a tie.
        if (therm_over)
            st_nxt.hot = 1'b1;
        else if (therm_cool)
            st_nxt.hot = 1'b0;
        st_nxt.drv = DRV_FWD;
        st_nxt.drv.low_current_limit = 1'b0;
        case (ctrl.state)
            ST_SCAN, ST_TIP_OPEN: begin
                st_nxt.drv.ac_path_en = 1'b0;
                st_nxt.drv.onhook_tx_en = 1'b0;
                st_nxt.drv.fixed_limit = 1'b1;
                st_nxt.drv.tip_hiz = ctrl.state == ST_TIP_OPEN;
            end
            ST_FWD_RCM: st_nxt.drv.raised_common_mode = 1'b1;
            ST_REV: st_nxt.drv.reverse = 1'b1;
            ST_WINK: st_nxt.drv.wink_ground = 1'b1;
            ST_RINGING: begin
                st_nxt.drv.ring_amp_en = 1'b1;
                st_nxt.drv.ac_path_en = 1'b0;
            end
            ST_DISC: begin
                st_nxt.drv = '0;
                st_nxt.drv.tip_hiz = 1'b1;
                st_nxt.drv.ring_hiz = 1'b1;
            end
            default: ;
        endcase
        if (!st_nxt.drv.fixed_limit) begin
            st_nxt.drv.low_current_limit = !ctrl.high_limit;
            st_nxt.drv.high_current_limit = ctrl.high_limit;
        end
        st_nxt.drv.test_load_pin = ctrl.test_load;
        if (st_nxt.hot) begin
            st_nxt.drv = '0;
            st_nxt.drv.all_off = 1'b1;
            st_nxt.drv.tip_hiz = 1'b1;
            st_nxt.drv.ring_hiz = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '{hot: 1'b0, drv: DRV_FWD};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign drive = st_r.drv;
    assign hot = st_r.hot;

    hyst_hold_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        st_r.hot && !therm_cool |=> st_r.hot)
        else $error("Shutdown released above the cool trip.");
endmodule

// ===== hdl/dual_line_state_control.sv
// Purpose: Two-channel line state control, serial link and AXI view.
// Assumes: aclk 125 MHz; link pins and analog flags are asynchronous.
// Notes: A frame is ten bits, channel one first, most significant first.
`timescale 1ns/100ps
`include "line_state_map.svh"

// Function
// - Power-up: active forward, low limit, test off.
// - Reset pin low forces both channels default.
// - Host sets state, limit, test per channel.
// - Status goes upstream on serial data output.
// - Five status bits per channel.
// - Current limit selects low or high only.
// - Forward, reverse and raised common mode states.
// - Scan: detector on, fixed limit, AC off.
// - Tip open is scan with tip high impedance.
// - Disconnect puts tip and ring high impedance.
// - Thermal shutdown forces the channel all off.
// - Cooled channel resumes programmed state, with hysteresis.
// - Ringing amplified only in ringing state.
module dual_line_state_control
    import line_state_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic [`ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // AXI4-Lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [`ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Device reset pin
    input wire logic line_reset_n,
    // Serial link
    input wire logic ser_en,
    input wire logic ser_clk,
    input wire logic ser_din,
    output logic ser_dout,
    // Detector flags, channel one in the low bits
    input wire logic [3:0] loop_closure,
    input wire logic [3:0] ring_trip,
    input wire logic [1:0] therm_over,
    input wire logic [1:0] therm_cool,
    // Line drive and interrupt
    output drive_s [1:0] line_drive,
    output logic irq
);
    localparam chan_ctrl_s CTL_DEF = chan_ctrl_s'(`CTL_RST);

    typedef struct packed {
        logic [11:0] pin1;
        logic [11:0] pin2;
        logic rst1;
        logic rst2;
        logic [3:0] loop_old;
        logic [1:0] hot_old;
        chan_ctrl_s [1:0] ctrl;
        link_e fsm;
        logic [3:0] cnt;
        logic [9:0] sh_in;
        logic [9:0] sh_out;
        logic dout;
        logic [`EV_W-1:0] ev;
        logic [`EV_W-1:0] mask;
        logic aw_have;
        logic [`ADDR_W-1:0] awaddr;
        logic w_have;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } top_s;

    localparam top_s TOP_RST = '{ctrl: {2{CTL_DEF}}, mask: `MASK_RST,
        fsm: LK_IDLE, default: '0};

    top_s st_r;
    top_s st_nxt;
    link_if lk ();
    logic [3:0] loop_s;
    logic [3:0] trip_s;
    logic [1:0] over_s;
    logic [1:0] cool_s;
    logic [1:0] hot;
    logic [1:0][4:0] sta;
    logic [9:0] snap;
    logic [`EV_W-1:0] ev_set;
    logic rd_clear;

    function automatic sel_e reg_sel(logic [`ADDR_W-1:0] a);
        case (a)
            `OFS_CTRL: reg_sel = SEL_CTRL;
            `OFS_STATUS: reg_sel = SEL_STATUS;
            `OFS_EVENT: reg_sel = SEL_EVENT;
            `OFS_MASK: reg_sel = SEL_MASK;
            default: reg_sel = SEL_NONE;
        endcase
    endfunction

    link_sampler u_link (
        .aclk (aclk),
        .aresetn (aresetn),
        .ser_en (ser_en),
        .ser_clk (ser_clk),
        .ser_din (ser_din),
        .lk (lk.sampler)
    );

    assign loop_s = st_r.pin2[3:0];
    assign trip_s = st_r.pin2[7:4];
    assign over_s = st_r.pin2[9:8];
    assign cool_s = st_r.pin2[11:10];

    for (genvar c = 0; c < 2; c++) begin : g_ch
        line_channel u_ch (
            .aclk (aclk),
            .aresetn (aresetn),
            .ctrl (st_r.ctrl[c]),
            .therm_over (over_s[c]),
            .therm_cool (cool_s[c]),
            .drive (line_drive[c]),
            .hot (hot[c])
        );
        // Thermal bit reports the latched shutdown, not the raw trip.
        assign sta[c][`FLD_THERM_BIT] = hot[c];
        assign sta[c][`FLD_TRIP_LSB +: 2] = trip_s[2*c +: 2];
        assign sta[c][`FLD_LOOP_LSB +: 2] = loop_s[2*c +: 2];
    end
    assign snap = {sta[0], sta[1]};

    always_comb begin
        st_nxt = st_r;
        ev_set = '0;
        rd_clear = 1'b0;
        st_nxt.pin1 = {therm_cool, therm_over, ring_trip, loop_closure};
        st_nxt.pin2 = st_r.pin1;
        st_nxt.rst1 = line_reset_n;
        st_nxt.rst2 = st_r.rst1;
        st_nxt.loop_old = loop_s;
        st_nxt.hot_old = hot;
        for (int c = 0; c < 2; c++) begin
            ev_set[`EV_THERM_LSB + c] = hot[c] & ~st_r.hot_old[c];
            ev_set[`EV_LOOP_LSB + c] =
                |(loop_s[2*c +: 2] ^ st_r.loop_old[2*c +: 2]);
        end

        // Serial frame engine; a frame opens on the enable rise and is checked the cycle after the enable fall.
        case (st_r.fsm)
            LK_IDLE: begin
                if (lk.en_rise) begin
                    st_nxt.sh_out = snap;
                    st_nxt.dout = snap[9];
                    st_nxt.cnt = 4'h0;
                    st_nxt.fsm = LK_SHIFT;
                end
            end
            LK_SHIFT: begin
                if (lk.clk_rise) begin
                    st_nxt.sh_in = {st_r.sh_in[8:0], lk.din};
                    if (st_r.cnt != 4'hf)
                        st_nxt.cnt = st_r.cnt + 4'h1;
                end
                if (lk.clk_fall) begin
                    st_nxt.sh_out = {st_r.sh_out[8:0], 1'b0};
                    st_nxt.dout = st_r.sh_out[8];
                end
                if (lk.en_fall)
                    st_nxt.fsm = LK_CHECK;
            end
            LK_CHECK: begin
                st_nxt.fsm = LK_IDLE;
                st_nxt.dout = 1'b0;
                // A frame of the wrong length is dropped whole.
                if (st_r.cnt == `FRAME_BITS && st_r.rst2) begin
                    st_nxt.ctrl[0] = chan_ctrl_s'(st_r.sh_in[9:5]);
                    st_nxt.ctrl[1] = chan_ctrl_s'(st_r.sh_in[4:0]);
                    ev_set[`EV_FRAME_OK] = 1'b1;
                end else begin
                    ev_set[`EV_FRAME_ERR] = 1'b1;
                end
            end
            default: st_nxt.fsm = LK_IDLE;
        endcase
        if (!st_r.rst2)
            st_nxt.ctrl = {2{CTL_DEF}};

        // Write path: address and data may arrive in either order.
        if (awvalid && awready) begin
            st_nxt.aw_have = 1'b1;
            st_nxt.awaddr = awaddr;
        end
        if (wvalid && wready) begin
            st_nxt.w_have = 1'b1;
            st_nxt.wdata = wdata;
            st_nxt.wstrb = wstrb;
        end
        if (st_r.aw_have && st_r.w_have) begin
            st_nxt.aw_have = 1'b0;
            st_nxt.w_have = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = `RESP_OKAY;
            case (reg_sel(st_r.awaddr))
                SEL_MASK: begin
                    if (st_r.wstrb[0])
                        st_nxt.mask = st_r.wdata[`EV_W-1:0];
                end
                SEL_NONE: st_nxt.bresp = `RESP_DECERR;
                default: ;
            endcase
        end
        if (st_r.bvalid && bready)
            st_nxt.bvalid = 1'b0;

        // Read path.
        if (arvalid && arready) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp = `RESP_OKAY;
            st_nxt.rdata = '0;
            case (reg_sel(araddr))
                SEL_CTRL: begin
                    st_nxt.rdata[`CTL_W-1:0] = st_r.ctrl[0];
                    st_nxt.rdata[`CH2_LSB +: `CTL_W] = st_r.ctrl[1];
                end
                SEL_STATUS: begin
                    st_nxt.rdata[4:0] = sta[0];
                    st_nxt.rdata[`CH2_LSB +: 5] = sta[1];
                end
                SEL_EVENT: begin
                    st_nxt.rdata[`EV_W-1:0] = st_r.ev;
                    rd_clear = 1'b1;
                end
                SEL_MASK: st_nxt.rdata[`EV_W-1:0] = st_r.mask;
                default: st_nxt.rresp = `RESP_DECERR;
            endcase
        end
        if (st_r.rvalid && rready)
            st_nxt.rvalid = 1'b0;
        // An event in the clearing cycle survives the read.
        st_nxt.ev = (rd_clear ? '0 : st_r.ev) | ev_set;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= TOP_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign awready = !st_r.aw_have && !st_r.bvalid;
    assign wready = !st_r.w_have && !st_r.bvalid;
    assign bvalid = st_r.bvalid;
    assign bresp = st_r.bresp;
    assign arready = !st_r.rvalid;
    assign rvalid = st_r.rvalid;
    assign rresp = st_r.rresp;
    assign rdata = st_r.rdata;
    assign ser_dout = st_r.dout;
    assign irq = |(st_r.ev & st_r.mask);

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    power_up_a: assert property (
        $rose(aresetn) |-> st_r.ctrl == {2{CTL_DEF}}
            && line_drive[0].low_current_limit
            && !line_drive[1].test_load_pin)
        else $error("Power-up state is not the default.");

    pin_reset_a: assert property (
        !line_reset_n [*3] |=> st_r.ctrl == {2{CTL_DEF}})
        else $error("Reset pin did not force the default state.");

    frame_load_a: assert property (
        st_r.fsm == LK_CHECK && st_r.cnt == `FRAME_BITS && st_r.rst2
        |=> st_r.ctrl == {$past(st_r.sh_in[4:0]), $past(st_r.sh_in[9:5])})
        else $error("Good frame did not load both channels.");

    frame_drop_a: assert property (
        st_r.fsm == LK_CHECK && st_r.cnt != `FRAME_BITS && st_r.rst2
        |=> $stable(st_r.ctrl))
        else $error("Bad frame changed the control state.");

    snap_take_a: assert property (
        st_r.fsm == LK_IDLE && lk.en_rise |=> st_r.sh_out == $past(snap))
        else $error("Status snapshot not taken at frame start.");

    dout_shift_a: assert property (
        st_r.fsm == LK_SHIFT && lk.clk_fall
        |=> ser_dout == $past(st_r.sh_out[8]))
        else $error("Serial output did not advance on falling edge.");

    therm_bit_a: assert property (
        st_r.fsm == LK_IDLE && lk.en_rise
        |=> st_r.sh_out[9] == $past(hot[0]) && st_r.sh_out[4] == $past(hot[1]))
        else $error("Thermal bit misplaced in status word.");

    for (genvar c = 0; c < 2; c++) begin : g_chk
        therm_off_a: assert property (
            over_s[c] |=> line_drive[c].all_off && line_drive[c].tip_hiz
                && line_drive[c].ring_hiz && !line_drive[c].ring_amp_en)
            else $error("Thermal trip did not force all off.");

        cool_back_a: assert property (
            hot[c] && cool_s[c] && !over_s[c]
            |=> !line_drive[c].all_off
                && line_drive[c].test_load_pin == $past(st_r.ctrl[c].test_load))
            else $error("Cooled channel did not resume its state.");

        limit_sel_a: assert property (
            !line_drive[c].fixed_limit && !line_drive[c].all_off
            |-> line_drive[c].low_current_limit
                != line_drive[c].high_current_limit)
            else $error("Current limit is not exactly one of two.");

        reverse_a: assert property (
            st_r.ctrl[c].state == ST_REV && !hot[c] && !over_s[c]
            |=> line_drive[c].reverse && !line_drive[c].raised_common_mode)
            else $error("Reverse state not applied.");

        scan_mode_a: assert property (
            st_r.ctrl[c].state == ST_SCAN && !hot[c] && !over_s[c]
            |=> line_drive[c].loop_det_en && line_drive[c].fixed_limit
                && !line_drive[c].ac_path_en && !line_drive[c].onhook_tx_en)
            else $error("Scan state drive is wrong.");

        tip_open_a: assert property (
            st_r.ctrl[c].state == ST_TIP_OPEN && !hot[c] && !over_s[c]
            |=> line_drive[c].tip_hiz && !line_drive[c].ring_hiz
                && line_drive[c].loop_det_en && line_drive[c].fixed_limit)
            else $error("Tip open state drive is wrong.");

        disc_hiz_a: assert property (
            st_r.ctrl[c].state == ST_DISC
            |=> line_drive[c].tip_hiz && line_drive[c].ring_hiz)
            else $error("Disconnect did not float tip and ring.");

        ring_only_a: assert property (
            line_drive[c].ring_amp_en
            |-> $past(st_r.ctrl[c].state) == ST_RINGING)
            else $error("Ringing amplified outside the ringing state.");
    end

    frame_ok_c: cover property (st_r.fsm == LK_CHECK
        && st_r.cnt == `FRAME_BITS);
    frame_err_c: cover property (ev_set[`EV_FRAME_ERR]);
    therm_trip_c: cover property ($rose(hot[0]) ##[1:200] $fell(hot[0]));
    ev_race_c: cover property (rd_clear && |ev_set);
endmodule

// ===== sim/link_host.sv
// Purpose: Host side of the serial link.
// Assumes: Four aclk cycles make one link clock level, a 64 ns period.
// Notes: Clock stands low between frames.
`timescale 1ns/100ps
module link_host (
    // Bench clock
    input wire logic aclk,
    // Serial pins
    output logic ser_en = 1'b0,
    output logic ser_clk = 1'b0,
    output logic ser_din = 1'b0,
    input wire logic ser_dout
);
    // Reply bits are caught on the aclk fall before each link clock fall,
    // when they have stood longest.
    task automatic frame(input logic [9:0] w, input int n,
                         output logic [9:0] got);
        got = '0;
        @(posedge aclk);
        ser_en <= 1'b1;
        ser_din <= w[9];
        repeat (5) @(posedge aclk);
        for (int i = 0; i < n; i++) begin
            ser_clk <= 1'b1;
            repeat (3) @(posedge aclk);
            @(negedge aclk);
            got = {got[8:0], ser_dout};
            @(posedge aclk);
            ser_clk <= 1'b0;
            ser_din <= (i < 9) ? w[8-i] : ~ser_din;
            repeat (4) @(posedge aclk);
        end
        ser_en <= 1'b0;
        ser_din <= ~ser_din;
        repeat (10) @(posedge aclk);
    endtask
endmodule

// ===== sim/testbench.sv
// Purpose: Self-checking bench of the line state controller.
// Assumes: link_host drives the serial pins.
// Notes: wstrb is tied high.
`timescale 1ns/100ps
`include "line_state_map.svh"
module testbench import line_state_pkg::*; ;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, line_reset_n = 1'b1;
    logic [3:0] loop_closure = 4'h0, ring_trip = 4'h0;
    logic [1:0] therm_over = 2'h0, therm_cool = 2'h0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic ser_en, ser_clk, ser_din, ser_dout;
    logic [1:0] bresp, rresp, r;
    logic [9:0] got;
    drive_s [1:0] ld;
    int err_total = 0;
    int n_compared = 0;

    initial forever #4 aclk = ~aclk;

    dual_line_state_control uut (
        .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
        .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready,
        .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .line_reset_n, .ser_en, .ser_clk, .ser_din, .ser_dout,
        .loop_closure, .ring_trip, .therm_over, .therm_cool,
        .line_drive(ld), .irq
    );
    link_host host (.aclk, .ser_en, .ser_clk, .ser_din, .ser_dout);

    task automatic chk(input string n, input logic [31:0] s, e);
        n_compared++;
        if (s !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic end_sim();
        if (err_total == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Ready and answer are looked at on the falling edge, where they have
    // settled; the handshake then completes at the following rising edge.
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic a_ok, w_ok, a_hit, w_hit, ok;
        a_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(a_ok && w_ok)) begin
            @(negedge aclk);
            a_hit = !a_ok && awready === 1'b1;
            w_hit = !w_ok && wready === 1'b1;
            @(posedge aclk);
            if (a_hit) awvalid <= 1'b0;
            if (w_hit) wvalid <= 1'b0;
            a_ok = a_ok || a_hit;
            w_ok = w_ok || w_hit;
        end
        do begin
            @(negedge aclk);
            ok = bvalid === 1'b1;
            r = bresp;
            @(posedge aclk);
        end while (!ok);
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        logic ok;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge aclk);
            ok = arready === 1'b1;
            @(posedge aclk);
        end while (!ok);
        arvalid <= 1'b0;
        do begin
            @(negedge aclk);
            ok = rvalid === 1'b1;
            d = rdata;
            r = rresp;
            @(posedge aclk);
        end while (!ok);
        rready <= 1'b0;
    endtask

    function automatic drive_s dflt();
        drive_s v;
        v = '0;
        v.loop_det_en = 1'b1;
        v.ac_path_en = 1'b1;
        v.onhook_tx_en = 1'b1;
        v.low_current_limit = 1'b1;
        return v;
    endfunction

    // Every state on channel one, the mirror state on channel two.
    task automatic t_states();
        logic [2:0] st;
        logic [4:0] c1, c2;
        loop_closure <= 4'b1001;
        ring_trip <= 4'b0110;
        for (int s = 0; s < 8; s++) begin
            st = 3'(s);
            c1 = {st[0], st[1], st};
            c2 = {~st[0], ~st[1], 3'h7 - st};
            host.frame({c1, c2}, 10, got);
            chk("dout", got, 10'h126);
            rd(`OFS_CTRL);
            chk("ctrl", d, {19'h0, c2, 3'h0, c1});
            chk("amp", ld[0].ring_amp_en, st == ST_RINGING);
            chk("rev", ld[0].reverse, st == ST_REV);
            chk("rcm", ld[0].raised_common_mode, st == ST_FWD_RCM);
            chk("wink", ld[0].wink_ground, st == ST_WINK);
            chk("rev2", ld[1].reverse, st == ST_TIP_OPEN);
            chk("tip", ld[0].tip_hiz,
                st inside {ST_TIP_OPEN, ST_DISC});
            chk("ring", ld[0].ring_hiz, st == ST_DISC);
            chk("tld", ld[0].test_load_pin, c1[4]);
            if (st inside {ST_FWD, ST_FWD_RCM, ST_REV})
                chk("lim", {ld[0].high_current_limit,
                    ld[0].low_current_limit}, {c1[3], ~c1[3]});
            if (st inside {ST_SCAN, ST_TIP_OPEN})
                chk("scan", {ld[0].loop_det_en, ld[0].fixed_limit,
                    ld[0].ac_path_en, ld[0].onhook_tx_en},
                    4'hc);
        end
        rd(`OFS_STATUS);
        chk("stat", d, 32'h0609);
    endtask

    // A short frame is dropped and raises a masked-in interrupt.
    task automatic t_bad();
        rd(`OFS_EVENT);
        wr(`OFS_MASK, 32'h20);
        chk("bresp", r, `RESP_OKAY);
        host.frame(10'h000, 9, got);
        rd(`OFS_CTRL);
        chk("keep", d, 32'h001f);
        chk("irq", irq, 1'b1);
        rd(`OFS_EVENT);
        chk("ev", d[5:4], 2'b10);
        @(negedge aclk);
        chk("irq0", irq, 1'b0);
        rd(8'h10);
        chk("resp", r, `RESP_DECERR);
        wr(8'h10, 32'h0);
        chk("bresp2", r, `RESP_DECERR);
    endtask

    // Hot channel one goes all off until the cool comparator trips.
    task automatic t_therm();
        therm_over <= 2'b01;
        repeat (6) @(posedge aclk);
        chk("off", ld[0].all_off, 1'b1);
        chk("off2", ld[1].all_off, 1'b0);
        therm_over <= 2'b00;
        repeat (6) @(posedge aclk);
        chk("hyst", ld[0].all_off, 1'b1);
        rd(`OFS_STATUS);
        chk("hot", d[4], 1'b1);
        rd(`OFS_EVENT);
        chk("tev", d[1:0], 2'b01);
        therm_cool <= 2'b01;
        repeat (6) @(posedge aclk);
        chk("back", {ld[0].all_off, ld[0].ring_hiz}, 2'b01);
        therm_cool <= 2'b00;
    endtask

    task automatic t_pin();
        line_reset_n <= 1'b0;
        repeat (8) @(posedge aclk);
        rd(`OFS_CTRL);
        chk("pin", d, 32'h0101);
        chk("pd0", ld[0], dflt());
        chk("pd1", ld[1], dflt());
        line_reset_n <= 1'b1;
    endtask

    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`OFS_CTRL);
        chk("rst", d, 32'h0101);
        chk("rdrv", ld[0], dflt());
        t_states();
        t_bad();
        t_therm();
        t_pin();
        end_sim();
    end

    initial begin
        #100000;
        err_total++;
        end_sim();
    end
endmodule
